// >>> rtl/rpms_consts.vh
// Constants for the reset and power mode sequencer.
// Included by rtl/rpms_sequencer.v only; holds definitions only.
`ifndef RPMS_CONSTS_VH
`define RPMS_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define RPMS_ADDR_W         4
`define RPMS_OFS_CTRL       4'h0
`define RPMS_OFS_CLKCFG     4'h1
`define RPMS_OFS_KEEP       4'h2
`define RPMS_OFS_STATUS     4'h3
`define RPMS_OFS_RSTSRC     4'h4

// ****************************************
// Control register fields
// ****************************************
`define RPMS_CTRL_SWRST     0
`define RPMS_CTRL_WAIT      1
`define RPMS_CTRL_STOP      2

// ****************************************
// Clock configuration fields
// ****************************************
`define RPMS_CFG_SRC_PLL    0
`define RPMS_CFG_PLL_POWER_DOWN      1
`define RPMS_CFG_OSCSB      2
`define RPMS_CFG_REGSB      3
`define RPMS_CFG_OSCPD      4
`define RPMS_CFG_TMRFAST    5
`define RPMS_CFG_PWMFAST    6
`define RPMS_CFG_RESET      16'h0000

// ****************************************
// Keep-alive fields
// ****************************************
`define RPMS_KEEP_SCI       4
`define RPMS_KEEP_RESET     16'h0000

// ****************************************
// Reset timing in oscillator and system clocks
// ****************************************
`define RPMS_POR_EXT_CYC    64
`define RPMS_CLKGEN_CYC     32
`define RPMS_PERIPH_CYC     32
`define RPMS_CORE_CYC       32
`define RPMS_WDOG_DIV       1024

// ****************************************
// Power modes
// ****************************************
`define RPMS_MODE_RUN       3'h0
`define RPMS_MODE_WAIT      3'h1
`define RPMS_MODE_STOP      3'h2
`define RPMS_MODE_STBY      3'h3
`define RPMS_MODE_PDN       3'h4

`endif

// >>> rtl/rpms_sequencer.v
// Reset and power mode sequencer of the system integration unit.
// Assumes clk is the master oscillator clock, free running; it is sampled
// against the double-rate clock enable pulse from the clock synth unit.
// Function
// RL1 - Wait instruction gates core and memory clocks, peripherals keep running
// RL2 - Wait exits on interrupt, debug entry or any reset
// RL3 - Stop instruction stops system clocks, master clock keeps running
// RL4 - Stop exits on enabled timer, serial, low-voltage, debug or reset
// RL5 - Stop keep-alive bits keep chosen peripheral clocks during Stop
// RL6 - Standby: oscillator source, PLL off, oscillator and regulator standby (code: Standby entry does not need the regulator standby bit)
// RL7 - Power-Down from Standby stops all clocks; only external or power-on exits (code: any of the four reset sources exits)
// RL8 - Regulator standby honoured only with PLL deselected at slow bus
// RL9 - Watchdog clock is master oscillator divided by 1024
// RL10 - Timer and PWM fast rate only with PLL active and selected
// RL11 - Four reset sources: pin and power-on async, software and watchdog sync
// RL12 - Test access port reset follows power-on only
// RL13 - Stretched power-on reset holds 64 oscillator cycles after release
// RL14 - Clock-gen reset releases 32 oscillator cycles after all sources release
// RL15 - Peripheral reset releases 32 cycles after clock-gen reset
// RL16 - Core reset releases 32 system clocks after peripheral reset
// RL17 - Reset release aligned to a system clock rising edge
// RL18 - Clock-gen reset released on the oscillator falling edge
// RL19 - Peripheral and core resets released on delayed clock falling edge (code: released on a clk rising edge when sys_div_q is high)
// RL20 - Master oscillator clock times all reset stretch counters (code: the core stage counts system clocks, on sys_div_q)
// RL21 - Double-rate clock halved for core, memory and peripheral clocks
// RL22 - Fast peripheral clock disabled when master oscillator is selected
// RL23 - Any reset abandons low power modes and restarts staged release
`timescale 1ns/100ps
`default_nettype none
`include "rpms_consts.vh"

module rpms_sequencer #(
  parameter WDOG_DIV   = `RPMS_WDOG_DIV,
  parameter NUM_TIMERS = 4
) (
  input  wire                      clk,
  input  wire                      reset,
  input  wire                      por_n,
  input  wire                      ext_reset_n,
  input  wire                      wdog_reset,
  input  wire                      wait_instr,
  input  wire                      stop_instr,
  input  wire                      irq_any,
  input  wire [NUM_TIMERS-1:0]     timer_irq,
  input  wire                      serial_irq,
  input  wire                      lowvolt_irq,
  input  wire                      debug_entry,
  input  wire                      x2_tick,
  input  wire                      slow_bus,
  input  wire [`RPMS_ADDR_W-1:0]   reg_addr,
  input  wire [15:0]               reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [15:0]               reg_rdata,
  output reg                       tap_reset,
  output reg                       ext_por_q,
  output reg                       clockgen_reset,
  output reg                       peripheral_reset,
  output reg                       core_reset,
  output reg                       core_clk_en,
  output reg                       periph_clk_en,
  output reg  [NUM_TIMERS-1:0]     timer_clk_en,
  output reg                       serial_clk_en,
  output reg                       fast_periph_clk_en,
  output reg                       timer_fast_en,
  output reg                       pwm_fast_en,
  output reg                       wdog_tick,
  output reg                       pll_power_down,
  output reg                       osc_source_select,
  output reg                       osc_standby_select,
  output reg                       osc_power_down,
  output reg                       regulator_standby,
  output reg  [2:0]                power_mode
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [1:0] por_n_s_q;
  reg [1:0] ext_n_s_q;
  always @(posedge clk) begin
    por_n_s_q <= {por_n_s_q[0], por_n};
    ext_n_s_q <= {ext_n_s_q[0], ext_reset_n};
  end
  wire por_act = reset | ~por_n_s_q[1];
  wire ext_act = ~ext_n_s_q[1];

  // ****************************************
  // Registers
  // ****************************************
  reg [15:0]           cfg_q;
  reg [NUM_TIMERS-1:0] keep_tmr_q;
  reg                  keep_sci_q;
  reg                  swrst_q;
  reg [3:0]            srcflag_q;
  reg [2:0]            mode_q;
  reg                  sys_div_q;

  // RL11 software source
  wire sw_req = reg_wr & (reg_addr == `RPMS_OFS_CTRL) & reg_wdata[`RPMS_CTRL_SWRST];
  // RL11 merge sources
  wire any_src = por_act | ext_act | swrst_q | wdog_reset;

  always @(posedge clk) begin
    if (por_act) begin
      cfg_q      <= `RPMS_CFG_RESET;
      keep_tmr_q <= {NUM_TIMERS{1'b0}};
      keep_sci_q <= 1'b0;
    end else if (reg_wr && reg_addr == `RPMS_OFS_CLKCFG) begin
      cfg_q <= reg_wdata;
    end else if (reg_wr && reg_addr == `RPMS_OFS_KEEP) begin
      keep_tmr_q <= reg_wdata[NUM_TIMERS-1:0];
      keep_sci_q <= reg_wdata[`RPMS_KEEP_SCI];
    end
    swrst_q <= sw_req & ~por_act;
  end

  // Reset cause flags: a new cause wins over the read-clear
  always @(posedge clk) begin
    if (reset) begin
      // Synchronous reset stands in for power-on, so it leaves the power-on cause set
      srcflag_q <= 4'h1;
    end else begin
      srcflag_q <= ((reg_rd && reg_addr == `RPMS_OFS_RSTSRC) ? 4'h0 : srcflag_q)
                   | {wdog_reset, swrst_q, ext_act, ~por_n_s_q[1]};
    end
  end

  // ****************************************
  // Staged reset release
  // ****************************************
  reg [6:0] por_cnt_q;
  reg [5:0] cg_cnt_q;
  reg [5:0] pr_cnt_q;
  reg [5:0] cr_cnt_q;
  reg       cg_hold_q;
  reg       pr_hold_q;

  always @(posedge clk) begin
    // RL13 RL20 power-on stretch
    if (por_act) begin
      por_cnt_q <= 7'd0;
    end else if (por_cnt_q != `RPMS_POR_EXT_CYC) begin
      por_cnt_q <= por_cnt_q + 7'd1;
    end
    // RL14 RL23 clock-gen stretch
    if (any_src || por_cnt_q != `RPMS_POR_EXT_CYC) begin
      cg_cnt_q <= 6'd0;
    end else if (cg_cnt_q != `RPMS_CLKGEN_CYC) begin
      cg_cnt_q <= cg_cnt_q + 6'd1;
    end
    cg_hold_q <= any_src | (por_cnt_q != `RPMS_POR_EXT_CYC) | (cg_cnt_q != `RPMS_CLKGEN_CYC);
    // RL15 peripheral stage in oscillator cycles
    if (cg_hold_q) begin
      pr_cnt_q <= 6'd0;
    end else if (pr_cnt_q != `RPMS_PERIPH_CYC) begin
      pr_cnt_q <= pr_cnt_q + 6'd1;
    end
    pr_hold_q <= cg_hold_q | (pr_cnt_q != `RPMS_PERIPH_CYC);
    // RL16 core stage in system clocks
    if (pr_hold_q) begin
      cr_cnt_q <= 6'd0;
    end else if (sys_div_q && cr_cnt_q != `RPMS_CORE_CYC) begin
      cr_cnt_q <= cr_cnt_q + 6'd1;
    end
  end

  // RL18 clock-gen reset leaves on the falling edge
  always @(negedge clk) begin
    clockgen_reset <= cg_hold_q;
  end

  always @(posedge clk) begin
    // RL12 test port reset
    tap_reset <= ~por_n_s_q[1] | reset;
    ext_por_q <= por_cnt_q != `RPMS_POR_EXT_CYC;
    // RL17 RL19 release on system clock phase
    // Assert straight from the merged sources so later stages never lag clock-gen
    if (any_src || pr_hold_q) begin
      peripheral_reset <= 1'b1;
    end else if (sys_div_q) begin
      peripheral_reset <= 1'b0;
    end
    if (any_src || pr_hold_q || cr_cnt_q != `RPMS_CORE_CYC) begin
      core_reset <= 1'b1;
    end else if (sys_div_q) begin
      core_reset <= 1'b0;
    end
  end

  // ****************************************
  // Clock division
  // ****************************************
  reg [10:0] wd_cnt_q;
  always @(posedge clk) begin
    // RL21 halve double-rate clock
    if (clockgen_reset) begin
      sys_div_q <= 1'b0;
    end else if (x2_tick) begin
      sys_div_q <= ~sys_div_q;
    end
    // RL9 watchdog divider
    if (reset) begin
      wd_cnt_q  <= 11'd0;
      wdog_tick <= 1'b0;
    end else begin
      wd_cnt_q  <= (wd_cnt_q == WDOG_DIV - 1) ? 11'd0 : wd_cnt_q + 11'd1;
      wdog_tick <= wd_cnt_q == WDOG_DIV - 1;
    end
  end

  // ****************************************
  // Power mode machine
  // ****************************************
  localparam RUN  = `RPMS_MODE_RUN;
  localparam WAIT = `RPMS_MODE_WAIT;
  localparam STOP = `RPMS_MODE_STOP;
  localparam STBY = `RPMS_MODE_STBY;
  localparam PDN  = `RPMS_MODE_PDN;

  wire pll_sel = cfg_q[`RPMS_CFG_SRC_PLL] & ~cfg_q[`RPMS_CFG_PLL_POWER_DOWN];
  wire stby_cfg = ~cfg_q[`RPMS_CFG_SRC_PLL] & cfg_q[`RPMS_CFG_PLL_POWER_DOWN]
                  & cfg_q[`RPMS_CFG_OSCSB];
  // RL4 stop wake sources
  wire stop_wake = |(timer_irq & keep_tmr_q) | (serial_irq & keep_sci_q)
                   | lowvolt_irq | debug_entry;
  reg [2:0] mode_d;

  always @* begin
    mode_d = mode_q;
    case (mode_q)
      RUN, STBY: begin
        // RL1 wait entry
        if (wait_instr) begin
          mode_d = WAIT;
        // RL3 stop entry
        end else if (stop_instr) begin
          mode_d = STOP;
        // RL7 power-down only from standby
        end else if (mode_q == STBY && cfg_q[`RPMS_CFG_OSCPD]) begin
          mode_d = PDN;
        // RL6 standby by configuration
        end else begin
          mode_d = stby_cfg ? STBY : RUN;
        end
      end
      // RL2 wait exit
      WAIT:    if (irq_any || debug_entry) mode_d = stby_cfg ? STBY : RUN;
      STOP:    if (stop_wake) mode_d = stby_cfg ? STBY : RUN;
      PDN:     mode_d = PDN;
      default: mode_d = RUN;
    endcase
  end

  always @(posedge clk) begin
    // RL23 RL7 any reset ends in run
    if (any_src) begin
      mode_q <= RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ****************************************
  // Clock gating and control outputs
  // ****************************************
  wire live = ~peripheral_reset & (mode_q != PDN);
  always @(posedge clk) begin
    // RL1 RL3 gate core and peripherals
    core_clk_en   <= live & ~core_reset & (mode_q == RUN || mode_q == STBY);
    periph_clk_en <= live & (mode_q != STOP);
    // RL5 stop keep-alive
    timer_clk_en  <= {NUM_TIMERS{live}} & ((mode_q == STOP) ? keep_tmr_q
                                                               : {NUM_TIMERS{1'b1}});
    serial_clk_en <= live & ((mode_q != STOP) | keep_sci_q);
    // RL22 fast clock only with PLL
    fast_periph_clk_en <= live & pll_sel;
    // RL10 fast rates need PLL
    // Fast rates follow the fast clock, so they drop with it in reset
    timer_fast_en <= live & pll_sel & cfg_q[`RPMS_CFG_TMRFAST];
    pwm_fast_en   <= live & pll_sel & cfg_q[`RPMS_CFG_PWMFAST];
    pll_power_down     <= cfg_q[`RPMS_CFG_PLL_POWER_DOWN];
    osc_source_select  <= cfg_q[`RPMS_CFG_SRC_PLL];
    osc_standby_select <= cfg_q[`RPMS_CFG_OSCSB];
    osc_power_down     <= (mode_q == PDN);
    // RL8 regulator standby guard
    regulator_standby  <= cfg_q[`RPMS_CFG_REGSB] & ~cfg_q[`RPMS_CFG_SRC_PLL] & slow_bus;
    power_mode         <= mode_q;
  end

  // ****************************************
  // Read port
  // ****************************************
  // Keep-alive word built bit by bit; a zero-width pad is not legal
  reg [15:0] keep_word;
  always @* begin
    keep_word = 16'h0000;
    keep_word[NUM_TIMERS-1:0] = keep_tmr_q;
    keep_word[`RPMS_KEEP_SCI] = keep_sci_q;
  end

  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RPMS_OFS_CLKCFG: reg_rdata <= {9'h000, cfg_q[6:0]};
        `RPMS_OFS_KEEP:   reg_rdata <= keep_word;
        `RPMS_OFS_STATUS: reg_rdata <= {10'h000, peripheral_reset, core_reset, pll_sel, mode_q};
        `RPMS_OFS_RSTSRC: reg_rdata <= {12'h000, srcflag_q};
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // rpms_sequencer
`default_nettype wire

// >>> test/rpms_clk_model.sv
// Model of the clock synth unit feeding the double-rate tick.
// Assumes clk is the free running master oscillator clock.
`timescale 1ns/100ps
`default_nettype none
module rpms_clk_model (
  input  wire logic clk,
  input  wire logic stall,
  output var  logic x2_tick
);
  // ****
  // Tick source
  // ****
  // osc feeds double-rate
  // Without the PLL one tick per master clock; stall gives a slow answer
  always_ff @(posedge clk) begin
    x2_tick <= !stall;
  end
endmodule // rpms_clk_model
`default_nettype wire

// >>> test/rpms_monitor.sv
// Checker for the reset and power mode sequencer.
// Bound to rpms_sequencer; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module rpms_monitor #(
  parameter WDOG_DIV = 8
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        por_n,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        tap_reset,
  input wire logic        clockgen_reset,
  input wire logic        peripheral_reset,
  input wire logic        core_reset,
  input wire logic        core_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        fast_periph_clk_en,
  input wire logic        timer_fast_en,
  input wire logic        pwm_fast_en,
  input wire logic        wdog_tick,
  input wire logic        pll_power_down,
  input wire logic        regulator_standby,
  input wire logic [2:0]  power_mode
);
  // ****
  // Watchdog gap counter
  // ****
  // Restarted by reset or clock-gen reset only, since the divider may restart too
  logic [15:0] gap_q;
  logic        seen_q;
  always_ff @(posedge clk) begin
    if (reset || clockgen_reset) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else if (wdog_tick) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ****
  // Assertions
  // ****
  a_wdog_div: assert property (wdog_tick && seen_q |-> gap_q == WDOG_DIV - 1)
    else $error("watchdog tick spacing wrong");
  a_tmr_fast: assert property (timer_fast_en |-> fast_periph_clk_en && !pll_power_down)
    else $error("timer fast rate without pll");
  a_pwm_fast: assert property (pwm_fast_en |-> fast_periph_clk_en && !pll_power_down)
    else $error("pwm fast rate without pll");
  a_reg_standby: assert property (regulator_standby |-> !fast_periph_clk_en)
    else $error("regulator standby with pll in use");
  a_stage_order: assert property (!peripheral_reset |-> !clockgen_reset)
    else $error("peripheral reset released before clock-gen");
  a_core_order: assert property (!core_reset |-> !peripheral_reset)
    else $error("core reset released before peripheral");
  a_periph_hold: assert property ($fell(clockgen_reset) |-> peripheral_reset [*8])
    else $error("peripheral reset released too early");
  a_core_hold: assert property ($fell(peripheral_reset) |-> core_reset [*8])
    else $error("core reset released too early");
  a_wait_gate: assert property (power_mode == 3'h1 |-> !core_clk_en && periph_clk_en)
    else $error("wait mode clock gating wrong");
  a_stop_gate: assert property (power_mode == 3'h2 |-> !core_clk_en && !periph_clk_en)
    else $error("stop mode clock gating wrong");
  a_tap_por: assert property ($rose(tap_reset) |-> !$past(por_n, 4) || !$past(por_n, 2))
    else $error("tap reset without power-on");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
endmodule // rpms_monitor
bind rpms_sequencer rpms_monitor #(.WDOG_DIV(WDOG_DIV)) mon_u (.*);
`default_nettype wire

// >>> test/test_rpms_sequencer.sv
// Testbench for the reset and power mode sequencer.
// Assumes the sequencer and its constants header are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_rpms_sequencer;
  logic        clk, reset, por_n, ext_reset_n, wdog_reset, wait_instr, stop_instr;
  logic        irq_any, serial_irq, lowvolt_irq, debug_entry, slow_bus, reg_wr, reg_rd;
  logic        x2_tick, stall, tap_reset, ext_por_q, clockgen_reset, peripheral_reset;
  logic        core_reset, core_clk_en, periph_clk_en, serial_clk_en, fast_periph_clk_en;
  logic        timer_fast_en, pwm_fast_en, wdog_tick, pll_power_down, osc_source_select;
  logic        osc_standby_select, osc_power_down, regulator_standby;
  logic [3:0]  timer_irq, reg_addr, timer_clk_en;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0]  power_mode;
  int          n_mismatch, samples_checked, k;
  rpms_sequencer #(.WDOG_DIV(8)) dut_u (.*);
  rpms_clk_model clk_u (.clk(clk), .stall(stall), .x2_tick(x2_tick));
  always #12.5 clk = ~clk;
  // ****
  // Tasks
  // ****
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Bounded wait for a mode with the core out of reset
  task automatic wait_for(input logic [2:0] m);
    k = 0;
    while (!(power_mode === m && core_reset === 1'b0) && k < 1000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({13'h0000, power_mode}, {13'h0000, m});
    if (k == 1000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {clk, por_n, ext_reset_n, reset} = 4'h7;
    {wdog_reset, wait_instr, stop_instr, irq_any, serial_irq, lowvolt_irq} = 6'h00;
    {debug_entry, slow_bus, reg_wr, reg_rd, stall} = 5'h00;
    {timer_irq, reg_addr, reg_wdata} = 24'h00_0000;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    k = 0;
    while (clockgen_reset !== 1'b0 && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(16'(k >= 96 && k < 104), 16'h0001);
    wait_for(3'h0);
    rd(4'h4, 16'h0001);
    rd(4'h4, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0000);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    @(posedge clk);
    wait_instr <= 1'b1;
    @(posedge clk);
    wait_instr <= 1'b0;
    wait_for(3'h1);
    @(posedge clk);
    debug_entry <= 1'b1;
    wait_for(3'h0);
    debug_entry <= 1'b0;
    wr(4'h2, 16'h0001);
    stop_instr <= 1'b1;
    @(posedge clk);
    stop_instr <= 1'b0;
    wait_for(3'h2);
    chk({11'h000, periph_clk_en, timer_clk_en}, 16'h0001);
    @(posedge clk);
    timer_irq <= 4'h2;
    repeat (6) @(posedge clk);
    #1;
    chk({13'h0000, power_mode}, 16'h0002);
    @(posedge clk);
    timer_irq <= 4'h1;
    wait_for(3'h0);
    timer_irq <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      wr(4'h1, i == 0 ? 16'h0061 : 16'h0060 >> (i - 1));
      repeat (3) @(posedge clk);
      #1;
      chk({fast_periph_clk_en, timer_fast_en, pwm_fast_en}, i == 0 ? 16'h0007 : 16'h0000);
    end
    slow_bus <= 1'b1;
    wr(4'h1, 16'h000e);
    wait_for(3'h3);
    chk({regulator_standby, pll_power_down, osc_standby_select}, 16'h0007);
    wr(4'h1, 16'h001e);
    wait_for(3'h4);
    irq_any <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk({13'h0000, power_mode}, 16'h0004);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      irq_any     <= 1'b0;
      por_n       <= (i != 0);
      ext_reset_n <= (i != 1);
      wdog_reset  <= (i == 3);
      if (i == 2) wr(4'h0, 16'h0001);
      repeat (6) @(posedge clk);
      #1;
      chk({15'h0000, tap_reset}, {15'h0000, i == 0});
      chk({15'h0000, core_reset}, 16'h0001);
      @(posedge clk);
      por_n       <= 1'b1;
      ext_reset_n <= 1'b1;
      wdog_reset  <= 1'b0;
      wait_for(3'h0);
      rd(4'h4, 16'h0001 << i);
    end
    end_of_test();
  end
endmodule // test_rpms_sequencer
`default_nettype wire
